/* verilog/pcs_cfg.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef PCS_CFG_SVH
`define PCS_CFG_SVH
`define PCS_DEVAD_PMA 5'h01
`define PCS_REG_CTRL1 16'h0000
`define PCS_REG_STAT1 16'h0001
`define PCS_BIT_SOFT_RESET 15
`define PCS_BIT_POWER_DOWN 11
`define PCS_BIT_LOOPBACK 0
`define PCS_BIT_LINK_UP 2
`define PCS_BIT_PD_CAPABLE 1
`define PCS_STAT1_RESET 16'h0002
`define PCS_CTRL1_RESET 16'h0000
`define PCS_RESET_NS 100
`define PCS_CLK_MHZ 200
`define PCS_RESET_CYCLES ((`PCS_RESET_NS * `PCS_CLK_MHZ + 999) / 1000)
`endif

/* verilog/pcs_pkg.sv */
// Types for the medium-attachment control and status registers
package pcs_pkg;
   typedef enum logic [1:0] {
      pcs_fn_address,
      pcs_fn_data,
      pcs_fn_data_inc_rw,
      pcs_fn_data_inc_w
   } pcs_fn_t;
   typedef struct packed {
      logic req;
      logic wr;
      logic [4:0] devad;
      logic [15:0] regad;
      logic [15:0] wdata;
   } pcs_req_t;
   typedef enum {pcs_st_run, pcs_st_reset} pcs_state_t;
endpackage

/* verilog/pcs_reset_timer.sv */
// Counter that times the whole-chip soft reset pulse
`timescale 1ns/1ps
module pcs_reset_timer #(
   parameter int CYCLES = 20
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic start,
   output logic busy
);
   logic [15:0] count;
   if (CYCLES < 1 || CYCLES > 65535) begin : g_bad_cycles
      $error("pcs_reset_timer: CYCLES out of range");
   end
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= 16'h0000;
         busy <= 1'b0;
      end else if (start) begin
         count <= 16'(CYCLES - 1);
         busy <= 1'b1;
      end else if (count != 16'h0000) begin
         count <= count - 16'h0001;
      end else begin
         busy <= 1'b0;
      end
   end
endmodule

/* verilog/pcs_regs.sv */
// Medium-attachment control and status registers with indirect access
// Overview of operation
// - Control at device 0x01 register 0x0000, status at register 0x0001.
// - Control reset value follows the power-down strap pin sampled at reset release.
// - Writing 1 to control bit 15 reinitialises the whole chip.
// - Reset bit self-clears; reads 1 only while reset runs.
// - Control bit 11 set puts the chip into low power.
// - Management access keeps working during software power-down.
// - Power-down default comes from a strap pin.
// - Control bit 0 loops transmit data back to receive.
// - Status bit 2 is link up, cleared if link dropped since last read.
// - Latched low link bit stays low until read, then follows link.
// - Status bit 1 always 1; status resets to 0x0002.
// - Indirect function field: address, data, inc on rw, inc on writes.
`timescale 1ns/1ps
`include "pcs_cfg.svh"
module pcs_regs
   import pcs_pkg::*;
#(
   parameter int RESET_CYCLES = `PCS_RESET_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire pcs_req_t direct_req,
   input wire logic acr_write,
   input wire logic [15:0] acr_wdata,
   input wire logic acc_req,
   input wire logic acc_wr,
   input wire logic [15:0] acc_wdata,
   input wire logic power_down_strap_pin,
   input wire logic link_ok,
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   input wire logic [7:0] line_rx_data,
   input wire logic line_rx_valid,
   output logic [15:0] rdata,
   output logic rvalid,
   output logic [15:0] acr_rdata,
   output logic whole_chip_soft_reset,
   output logic soft_power_down,
   output logic local_loopback_enable,
   output logic chip_reset_n,
   output logic [7:0] rx_data,
   output logic rx_valid
);
   pcs_state_t state;
   pcs_fn_t indirect_access_function;
   logic [4:0] acr_devad;
   logic [15:0] mmd_addr;
   logic strap_taken;
   logic latched_link_up;
   logic reset_busy;
   logic start_reset;
   logic acc_data;
   logic sel_ctrl;
   logic sel_stat;
   logic eff_req;
   logic eff_wr;
   logic [4:0] eff_devad;
   logic [15:0] eff_regad;
   logic [15:0] eff_wdata;
   logic [15:0] next_rdata;

   // Indirect path steers through the access-control function field
   assign acc_data = acc_req &&
      (indirect_access_function != pcs_fn_address);
   assign eff_req = direct_req.req | acc_data;
   assign eff_wr = direct_req.req ? direct_req.wr : acc_wr;
   assign eff_devad = direct_req.req ? direct_req.devad : acr_devad;
   assign eff_regad = direct_req.req ? direct_req.regad : mmd_addr;
   assign eff_wdata = direct_req.req ? direct_req.wdata : acc_wdata;
   assign sel_ctrl = eff_req && eff_devad == `PCS_DEVAD_PMA &&
      eff_regad == `PCS_REG_CTRL1;
   assign sel_stat = eff_req && eff_devad == `PCS_DEVAD_PMA &&
      eff_regad == `PCS_REG_STAT1;
   assign start_reset = sel_ctrl && eff_wr &&
      eff_wdata[`PCS_BIT_SOFT_RESET] && state == pcs_st_run;

   pcs_reset_timer #(
      .CYCLES(RESET_CYCLES)
   ) u_timer (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .start(start_reset),
      .busy(reset_busy)
   );

   // Access-control register and indirect address pointer
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         indirect_access_function <= pcs_fn_address;
         acr_devad <= 5'h00;
         mmd_addr <= 16'h0000;
      end else begin
         if (acr_write) begin
            indirect_access_function <= pcs_fn_t'(acr_wdata[15:14]);
            acr_devad <= acr_wdata[4:0];
         end
         // A direct access in the same cycle wins; the pointer holds
         if (acc_req && !direct_req.req) begin
            case (indirect_access_function)
               pcs_fn_address: mmd_addr <= acc_wdata;
               pcs_fn_data_inc_rw: mmd_addr <= mmd_addr + 16'h0001;
               pcs_fn_data_inc_w: begin
                  if (acc_wr) begin
                     mmd_addr <= mmd_addr + 16'h0001;
                  end
               end
               default: mmd_addr <= mmd_addr;
            endcase
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         acr_rdata <= 16'h0000;
      end else begin
         acr_rdata <= {indirect_access_function, 9'h000, acr_devad};
      end
   end

   // Reset sequencing state
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= pcs_st_run;
      end else begin
         case (state)
            pcs_st_run: begin
               if (start_reset) begin
                  state <= pcs_st_reset;
               end
            end
            pcs_st_reset: begin
               if (!reset_busy) begin
                  state <= pcs_st_run;
               end
            end
            default: state <= pcs_st_run;
         endcase
      end
   end

   // Control register; strap reloads power-down on every reset
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         whole_chip_soft_reset <= 1'b0;
         soft_power_down <= 1'b0;
         local_loopback_enable <= 1'b0;
         strap_taken <= 1'b0;
         chip_reset_n <= 1'b0;
      end else begin
         chip_reset_n <= (state == pcs_st_run) && !start_reset;
         whole_chip_soft_reset <= start_reset ||
            (state == pcs_st_reset && reset_busy);
         if (!strap_taken || (state == pcs_st_reset && !reset_busy)) begin
            strap_taken <= 1'b1;
            soft_power_down <= power_down_strap_pin;
            local_loopback_enable <= 1'b0;
         end else if (sel_ctrl && eff_wr && !start_reset) begin
            // Writes allowed even while powered down
            soft_power_down <= eff_wdata[`PCS_BIT_POWER_DOWN];
            local_loopback_enable <= eff_wdata[`PCS_BIT_LOOPBACK];
         end
      end
   end

   // Latch-low link status; a drop during the read still wins
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         latched_link_up <= 1'b0;
      end else if (!link_ok || soft_power_down) begin
         latched_link_up <= 1'b0;
      end else if (sel_stat && !eff_wr) begin
         latched_link_up <= 1'b1;
      end
   end

   always_comb begin
      next_rdata = 16'h0000;
      if (sel_ctrl) begin
         next_rdata[`PCS_BIT_SOFT_RESET] = whole_chip_soft_reset;
         next_rdata[`PCS_BIT_POWER_DOWN] = soft_power_down;
         next_rdata[`PCS_BIT_LOOPBACK] = local_loopback_enable;
      end else if (sel_stat) begin
         next_rdata = `PCS_STAT1_RESET;
         next_rdata[`PCS_BIT_LINK_UP] = latched_link_up;
      end
   end

   // Read data, valid one cycle after the request
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= 16'h0000;
         rvalid <= 1'b0;
      end else begin
         rvalid <= eff_req && !eff_wr;
         if (eff_req && !eff_wr) begin
            rdata <= next_rdata;
         end
      end
   end

   // Receive path mux: loopback returns transmit data
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_data <= 8'h00;
         rx_valid <= 1'b0;
      end else if (soft_power_down) begin
         rx_data <= 8'h00;
         rx_valid <= 1'b0;
      end else if (local_loopback_enable) begin
         rx_data <= tx_data;
         rx_valid <= tx_valid;
      end else begin
         rx_data <= line_rx_data;
         rx_valid <= line_rx_valid;
      end
   end

   a_status_pd_capable: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      rvalid && $past(sel_stat) |-> rdata[1])
      else $error("Power-down capable bit not set");
   a_link_drop_latch: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      !link_ok |=> !latched_link_up)
      else $error("Link drop not latched");
   a_link_hold_low: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      !latched_link_up && !(sel_stat && !eff_wr) |=> !latched_link_up)
      else $error("Latched link rose without a read");
   a_reset_start: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      start_reset |=> whole_chip_soft_reset && !chip_reset_n)
      else $error("Soft reset did not start");
   a_reset_clears: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      state == pcs_st_reset && !reset_busy |=> !whole_chip_soft_reset)
      else $error("Soft reset bit did not clear");
   a_loop_path: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      local_loopback_enable && !soft_power_down |=>
      rx_data == $past(tx_data))
      else $error("Loopback data mismatch");
   a_pd_write: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      strap_taken && sel_ctrl && eff_wr && !start_reset &&
      state == pcs_st_run |=>
      soft_power_down == $past(eff_wdata[`PCS_BIT_POWER_DOWN]))
      else $error("Power-down bit not written");
   a_pd_quiet_rx: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      soft_power_down |=> !rx_valid)
      else $error("Receive active in power-down");
   a_rsvd_zero: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      rvalid |-> rdata[14:12] == 3'h0 && rdata[10:3] == 8'h00)
      else $error("Reserved bits not zero");
endmodule

/* verif/pcs_line_model.sv */
// Line-side partner: link state and bytes arriving from the medium
`timescale 1ns/1ps
module pcs_line_model (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic drop,
   output logic link_ok,
   output logic [7:0] line_rx_data,
   output logic line_rx_valid
);
   // Link falls while drop is high; data inverts then, else idles at 3C
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         link_ok <= 1'b0;
         line_rx_valid <= 1'b0;
         line_rx_data <= 8'h00;
      end else begin
         link_ok <= !drop;
         line_rx_valid <= !drop;
         line_rx_data <= drop ? ~line_rx_data : 8'h3C;
      end
   end
endmodule

/* verif/tb_pcs_regs.sv */
// Self-checking bench for the medium-attachment registers
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
   $display("BAD %s exp %h got %h", n, e, g); end end
module tb_pcs_regs
   import pcs_pkg::*;
();
   localparam int RC = 8;
   logic sys_clk, rst_n, acr_write, acc_req, acc_wr, strap, link_ok, drop;
   logic tx_valid, line_rx_valid, rvalid, rst_bit, pd, lb;
   logic chip_rst_n, rx_valid;
   logic [15:0] acr_wdata, acc_wdata, rdata, acr_rdata;
   logic [7:0] tx_data, line_rx_data, rx_data;
   pcs_req_t dreq;
   int n_errors = 0;
   int n_checks = 0;
   pcs_regs #(.RESET_CYCLES(RC)) dut (.sys_clk(sys_clk), .rst_n(rst_n),
      .direct_req(dreq), .acr_write(acr_write), .acr_wdata(acr_wdata),
      .acc_req(acc_req), .acc_wr(acc_wr), .acc_wdata(acc_wdata),
      .power_down_strap_pin(strap), .link_ok(link_ok), .tx_data(tx_data),
      .tx_valid(tx_valid), .line_rx_data(line_rx_data),
      .line_rx_valid(line_rx_valid), .rdata(rdata), .rvalid(rvalid),
      .acr_rdata(acr_rdata), .whole_chip_soft_reset(rst_bit),
      .soft_power_down(pd), .local_loopback_enable(lb),
      .chip_reset_n(chip_rst_n), .rx_data(rx_data), .rx_valid(rx_valid));
   pcs_line_model far (.sys_clk(sys_clk), .rst_n(rst_n), .drop(drop),
      .link_ok(link_ok), .line_rx_data(line_rx_data),
      .line_rx_valid(line_rx_valid));
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   task automatic give_verdict();
      if (n_errors == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      #20000;
      n_errors++;
      give_verdict();
   end
   // One direct or indirect access; reads are compared with valid
   task automatic go(input bit ind, input bit wr, input logic [4:0] dv,
         input logic [15:0] ra, input logic [15:0] d, input logic [15:0] e);
      int k;
      k = 0;
      @(posedge sys_clk);
      if (ind) begin
         acc_req <= 1'b1;
         acc_wr <= wr;
         acc_wdata <= d;
      end else dreq <= '{1'b1, wr, dv, ra, d};
      @(posedge sys_clk);
      acc_req <= 1'b0;
      dreq.req <= 1'b0;
      if (!wr) begin
         #1;
         while (rvalid !== 1'b1 && k < 3) begin
            @(posedge sys_clk);
            #1;
            k++;
         end
         `CHK("rdata", {1'b1, e}, {rvalid, rdata})
      end
   endtask
   // Access-control write for device 1, then readback
   task automatic acr(input logic [1:0] fn);
      @(posedge sys_clk);
      acr_write <= 1'b1;
      acr_wdata <= {fn, 9'h000, 5'h01};
      @(posedge sys_clk);
      acr_write <= 1'b0;
      @(posedge sys_clk);
      #1;
      `CHK("acr", {fn, 9'h000, 5'h01}, acr_rdata)
   endtask
   initial begin
      int k;
      rst_n = 1'b0;
      dreq = '0;
      acr_write = 1'b0;
      acr_wdata = '0;
      acc_req = 1'b0;
      acc_wr = 1'b0;
      acc_wdata = '0;
      tx_data = '0;
      tx_valid = 1'b0;
      drop = 1'b0;
      strap = 1'b1;
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge sys_clk);
      go(0, 0, 5'h01, 16'h0000, '0, 16'h0800);
      `CHK("pd", 1'b1, pd)
      `CHK("rxv", 1'b0, rx_valid)
      go(0, 1, 5'h01, 16'h0000, 16'h77FE, '0);
      go(0, 0, 5'h01, 16'h0000, '0, 16'h0000);
      go(0, 0, 5'h01, 16'h0001, '0, 16'h0002);
      go(0, 0, 5'h01, 16'h0001, '0, 16'h0006);
      go(0, 1, 5'h01, 16'h0001, 16'hFFFF, '0);
      go(0, 0, 5'h01, 16'h0001, '0, 16'h0006);
      go(0, 0, 5'h03, 16'h0000, '0, 16'h0000);
      go(0, 0, 5'h01, 16'h0005, '0, 16'h0000);
      `CHK("rx", 9'h13C, {rx_valid, rx_data})
      go(0, 1, 5'h01, 16'h0000, 16'h0001, '0);
      tx_data <= 8'hA5;
      tx_valid <= 1'b1;
      repeat (3) @(posedge sys_clk);
      #1;
      `CHK("lb", 10'h3A5, {lb, rx_valid, rx_data})
      @(posedge sys_clk);
      drop <= 1'b1;
      @(posedge sys_clk);
      drop <= 1'b0;
      go(0, 0, 5'h01, 16'h0001, '0, 16'h0002);
      go(0, 0, 5'h01, 16'h0001, '0, 16'h0006);
      acr(2'b00);
      go(1, 1, 5'h00, '0, 16'h0000, '0);
      acr(2'b01);
      go(1, 1, 5'h00, '0, 16'h0800, '0);
      go(1, 0, 5'h00, '0, '0, 16'h0800);
      `CHK("pd", 1'b1, pd)
      go(1, 1, 5'h00, '0, 16'h0000, '0);
      acr(2'b10);
      go(1, 0, 5'h00, '0, '0, 16'h0000);
      go(1, 0, 5'h00, '0, '0, 16'h0002);
      acr(2'b00);
      go(1, 1, 5'h00, '0, 16'h0000, '0);
      acr(2'b11);
      go(1, 0, 5'h00, '0, '0, 16'h0000);
      go(1, 1, 5'h00, '0, 16'h0000, '0);
      go(1, 0, 5'h00, '0, '0, 16'h0006);
      @(posedge sys_clk);
      strap <= 1'b0;
      go(0, 1, 5'h01, 16'h0000, 16'h0801, '0);
      go(0, 1, 5'h01, 16'h0000, 16'h8801, '0);
      go(0, 0, 5'h01, 16'h0000, '0, 16'h8801);
      `CHK("srst", 2'b10, {rst_bit, chip_rst_n})
      k = 0;
      while (chip_rst_n !== 1'b1 && k < 4 * RC) begin
         @(posedge sys_clk);
         #1;
         k++;
      end
      `CHK("srst_len", RC, k)
      `CHK("srst_bit", 1'b0, rst_bit)
      repeat (2) @(posedge sys_clk);
      go(0, 0, 5'h01, 16'h0000, '0, 16'h0000);
      give_verdict();
   end
endmodule
